// ==== dwit_params.svh ====
// Constants for the dual wiper two-wire target: addresses, field positions, counts.
// Assumes inclusion by the package and by the design modules.
`ifndef DWIT_PARAMS_SVH
`define DWIT_PARAMS_SVH

`define DWIT_WIPER_W       8
`define DWIT_NUM_CHAN      2
`define DWIT_MIDSCALE      8'h80
`define DWIT_FIXED_ADDR    7'h2F
`define DWIT_UPPER_ADDR    5'h0B
`define DWIT_BYTE_BITS     4'h8
`define DWIT_ACK_SLOT      4'h9
`define DWIT_CHAN_BIT      7
`define DWIT_PARK_BIT      6
`define DWIT_RW_BIT        0
`define DWIT_SYNC_STAGES   3

`endif

// ==== dwit_pkg.sv ====
// Types shared by the dual wiper two-wire target modules.
// Assumes dwit_params.svh is on the include path.
`include "dwit_params.svh"

package dwit_pkg;

  typedef enum logic [2:0] {
    st_idle,
    st_addr,
    st_instr,
    st_data,
    st_read
  } dwit_state_t;

  // Word handed from the link domain to the system domain on each accepted instruction or data byte
  typedef struct packed {
    logic                       chan;
    logic                       park;
    logic                       has_data;
    logic [`DWIT_WIPER_W-1:0]   data;
  } dwit_evt_t;

endpackage

// ==== dwit_pin_sync.sv ====
// Three-stage synchroniser with agreement filter, one lane per bit.
// Assumes inputs are asynchronous to clk; output moves once stages two and three agree.
`timescale 1ns/10ps

module dwit_pin_sync #(
  parameter int          W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,       // Sampling clock
  input  wire logic         nrst,      // Asynchronous reset, active low
  input  wire logic [W-1:0] pin_async, // Asynchronous inputs
  output logic      [W-1:0] level      // Filtered synchronous levels
);

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_lane
      logic s1_ff;
      logic s2_ff;
      logic s3_ff;
      logic lvl_ff;
      logic nxt_lvl;
      // The first stage feeds only the second stage
      assign nxt_lvl = (s2_ff == s3_ff) ? s3_ff : lvl_ff;
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          s1_ff  <= RST_VAL[g];
          s2_ff  <= RST_VAL[g];
          s3_ff  <= RST_VAL[g];
          lvl_ff <= RST_VAL[g];
        end else begin
          s1_ff  <= pin_async[g];
          s2_ff  <= s1_ff;
          s3_ff  <= s2_ff;
          lvl_ff <= nxt_lvl;
        end
      end
      assign level[g] = lvl_ff;
    end
  endgenerate

endmodule

// ==== dwit_target.sv ====
// Dual wiper two-wire target: link engine on link_clk, wiper settings on sys_clk.
// Assumes SCL/SDA are open-drain pins resolved outside; straps are static levels.
//
// Behaviour
// (R1) A falling SDA while SCL high opens a new frame.
// (R2) Controller sends seven address bits then the direction bit after START.
// (R3) Fixed address variant, or strap variant taking two low address bits from straps.
// (R4) Matching address is acknowledged by pulling SDA low in the ninth pulse.
// (R5) A mismatched target stays idle, never driving SDA, until next START.
// (R6) Direction high selects read, low selects write.
// (R7) First written byte is the instruction; its top bit picks channel 1 or 2.
// (R8) Instruction bit six drives the shutdown output.
// (R9) Shutdown keeps stored settings; they drive the network again afterwards.
// (R10) Settings written during shutdown are stored and used once shutdown ends.
// (R11) The six low instruction bits are ignored.
// (R12) Byte after instruction is data; nine pulses per byte, MSB first.
// (R13) SDA changes only while SCL is low, except START and STOP.
// (R14) In read mode data follows the address acknowledge directly.
// (R15) A read returns the channel picked by the latest instruction byte.
// (R16) A write may end after the instruction; channel recorded, settings untouched.
// (R17) Rising SDA while SCL high ends the frame and returns to idle.
// (R18) Controller ends a read with a not-acknowledge then STOP.
// (R19) Every further data byte in the same write updates the chosen channel.
// (R20) Changing channel or shutdown needs a new frame; later bytes are data.
// (R21) While the controller acknowledges, reads keep sending the setting.
// (R22) Both wiper settings start at midscale.
// (R23) Each channel holds an eight-bit setting selecting one of 256 taps.
// (R24) Midscale is 0x80; shutdown clear and channel 1 selected at reset.
// (R25) Address parts are parameters; unexpected START or STOP abandons a frame.
`timescale 1ns/10ps
`include "dwit_params.svh"

module dwit_target #(
  parameter bit         STRAP_EN   = 1'b0,              // Strap address variant
  parameter logic [6:0] FIXED_ADDR = `DWIT_FIXED_ADDR,  // Address when straps unused
  parameter logic [4:0] UPPER_ADDR = `DWIT_UPPER_ADDR   // Upper bits for strap variant
) (
  input  wire logic                     sys_clk,          // System clock
  input  wire logic                     nrst,             // Async reset, active low
  input  wire logic                     link_clk,         // Link sampling clock
  input  wire logic                     scl_i,            // SCL pin level
  input  wire logic                     sda_i,            // SDA pin level
  output logic                          sda_o,            // SDA drive value, always low
  output logic                          sda_oe_n,         // SDA enable, low pulls pin
  input  wire logic                     addr_strap_low,   // Address strap, bit 0
  input  wire logic                     addr_strap_high,  // Address strap, bit 1
  output logic [`DWIT_WIPER_W-1:0]      wiper_setting_1,  // Channel 1 setting
  output logic [`DWIT_WIPER_W-1:0]      wiper_setting_2,  // Channel 2 setting
  output logic                          wiper_park,       // Shutdown output
  output logic                          channel_select_bit // Last chosen channel
);

  localparam int WW = `DWIT_WIPER_W;
  localparam int NC = `DWIT_NUM_CHAN;

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: pin sampling and edge decode

  logic [3:0] pins_s;
  logic       scl_f, sda_f;
  logic [1:0] strap_s;
  logic       scl_q_ff;
  logic       sda_q_ff;

  dwit_pin_sync #(
    .W       (4),
    .RST_VAL (4'h3)
  ) u_link_sync (
    .clk       (link_clk),
    .nrst      (nrst),
    .pin_async ({addr_strap_high, addr_strap_low, sda_i, scl_i}),
    .level     (pins_s)
  );

  assign scl_f   = pins_s[0];
  assign sda_f   = pins_s[1];
  assign strap_s = pins_s[3:2];

  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
    end else begin
      scl_q_ff <= scl_f;
      sda_q_ff <= sda_f;
    end
  end

  wire start_det = scl_f & scl_q_ff & sda_q_ff & ~sda_f; // R1
  wire stop_det  = scl_f & scl_q_ff & ~sda_q_ff & sda_f; // R17
  wire scl_rise  = scl_f & ~scl_q_ff;
  wire scl_fall  = ~scl_f & scl_q_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: frame engine

  dwit_pkg::dwit_state_t st_ff, nxt_st;
  dwit_pkg::dwit_evt_t   evt_ff, nxt_evt;
  logic [3:0]            cnt_ff, nxt_cnt;
  logic [WW-1:0]         rx_ff, nxt_rx;
  logic [WW-1:0]         tx_ff, nxt_tx;
  logic                  pull_ff, nxt_pull;
  logic                  rw_ff, nxt_rw;
  logic                  chan_ff, nxt_chan;
  logic                  park_ff, nxt_park;
  logic                  mack_ff, nxt_mack;
  logic                  tgl_ff, nxt_tgl;
  logic                  shadow_we;
  logic [WW-1:0]         shadow [NC];

  // Strap variant takes its two low bits from the straps
  wire [6:0] own_addr = STRAP_EN ? {UPPER_ADDR, strap_s} : FIXED_ADDR; // R3 R25
  wire       addr_hit = (rx_ff[7:1] == own_addr);                       // R3
  wire       byte_end = scl_fall && (cnt_ff == `DWIT_BYTE_BITS);
  wire       ack_end  = scl_fall && (cnt_ff == `DWIT_ACK_SLOT);
  wire [WW-1:0] shadow_sel = shadow[chan_ff];                          // R15
  wire       mid_bit  = scl_fall && (cnt_ff != 4'h0) && (cnt_ff < `DWIT_BYTE_BITS);

  always_comb begin
    nxt_st    = st_ff;
    nxt_cnt   = cnt_ff;
    nxt_rx    = rx_ff;
    nxt_tx    = tx_ff;
    nxt_pull  = pull_ff;
    nxt_rw    = rw_ff;
    nxt_chan  = chan_ff;
    nxt_park  = park_ff;
    nxt_mack  = mack_ff;
    nxt_evt   = evt_ff;
    nxt_tgl   = tgl_ff;
    shadow_we = 1'b0;
    if (start_det) begin
      nxt_st   = dwit_pkg::st_addr; // R1 R25
      nxt_cnt  = 4'h0;
      nxt_pull = 1'b0;
    end else if (stop_det) begin
      nxt_st   = dwit_pkg::st_idle; // R17 R25
      nxt_cnt  = 4'h0;
      nxt_pull = 1'b0;
    end else if (st_ff != dwit_pkg::st_idle) begin
      if (scl_rise) begin
        if (cnt_ff < `DWIT_BYTE_BITS) begin
          nxt_rx = {rx_ff[WW-2:0], sda_f}; // R12
        end
        if (cnt_ff == `DWIT_BYTE_BITS) begin
          nxt_mack = ~sda_f; // R21
        end
        nxt_cnt = 4'(cnt_ff + 4'h1);
      end else if (scl_fall) begin
        // Apart from START and STOP, drive changes happen on SCL falling edges only
        case (st_ff) // R13
          dwit_pkg::st_addr: begin
            if (byte_end && addr_hit) begin
              nxt_pull = 1'b1; // R4
              nxt_rw   = rx_ff[`DWIT_RW_BIT]; // R6
            end else if (byte_end) begin
              nxt_st = dwit_pkg::st_idle; // R5
            end else if (ack_end) begin
              nxt_cnt = 4'h0;
              if (rw_ff) begin
                nxt_st   = dwit_pkg::st_read; // R6 R14
                nxt_tx   = shadow_sel;
                nxt_pull = ~shadow_sel[WW-1];
              end else begin
                nxt_st   = dwit_pkg::st_instr; // R6
                nxt_pull = 1'b0;
              end
            end
          end
          dwit_pkg::st_instr: begin
            if (byte_end) begin
              // Low six bits are dropped here
              nxt_pull     = 1'b1;
              nxt_chan     = rx_ff[`DWIT_CHAN_BIT]; // R7 R11
              nxt_park     = rx_ff[`DWIT_PARK_BIT]; // R8 R11
              nxt_evt.chan = rx_ff[`DWIT_CHAN_BIT];
              nxt_evt.park = rx_ff[`DWIT_PARK_BIT];
              nxt_evt.has_data = 1'b0; // R16
              nxt_tgl      = ~tgl_ff;
            end else if (ack_end) begin
              nxt_pull = 1'b0;
              nxt_cnt  = 4'h0;
              nxt_st   = dwit_pkg::st_data; // R12 R20
            end
          end
          dwit_pkg::st_data: begin
            if (byte_end) begin
              nxt_pull  = 1'b1;
              shadow_we = 1'b1; // R19
              nxt_evt   = '{chan: chan_ff, park: park_ff, has_data: 1'b1, data: rx_ff};
              nxt_tgl   = ~tgl_ff;
            end else if (ack_end) begin
              nxt_pull = 1'b0;
              nxt_cnt  = 4'h0; // R19 R20
            end
          end
          dwit_pkg::st_read: begin
            if (mid_bit) begin
              nxt_tx   = {tx_ff[WW-2:0], 1'b0}; // R12
              nxt_pull = ~tx_ff[WW-2];
            end else if (byte_end) begin
              nxt_pull = 1'b0;
            end else if (ack_end) begin
              nxt_cnt = 4'h0;
              if (mack_ff) begin
                nxt_tx   = shadow_sel; // R21
                nxt_pull = ~shadow_sel[WW-1];
              end else begin
                nxt_st = dwit_pkg::st_idle;
              end
            end
          end
          default: begin
            nxt_st   = dwit_pkg::st_idle;
            nxt_pull = 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      st_ff   <= dwit_pkg::st_idle;
      cnt_ff  <= 4'h0;
      rx_ff   <= 8'h00;
      tx_ff   <= 8'h00;
      pull_ff <= 1'b0;
      rw_ff   <= 1'b0;
      chan_ff <= 1'b0; // R24
      park_ff <= 1'b0; // R24
      mack_ff <= 1'b0;
      tgl_ff  <= 1'b0;
      evt_ff  <= '{chan: 1'b0, park: 1'b0, has_data: 1'b0, data: `DWIT_MIDSCALE};
    end else begin
      st_ff   <= nxt_st;
      cnt_ff  <= nxt_cnt;
      rx_ff   <= nxt_rx;
      tx_ff   <= nxt_tx;
      pull_ff <= nxt_pull;
      rw_ff   <= nxt_rw;
      chan_ff <= nxt_chan;
      park_ff <= nxt_park;
      mack_ff <= nxt_mack;
      tgl_ff  <= nxt_tgl;
      evt_ff  <= nxt_evt;
    end
  end

  // Link-side copy of the settings serves reads without a round trip
  genvar gc;
  generate
    for (gc = 0; gc < NC; gc++) begin : g_shadow
      logic [WW-1:0] sh_ff;
      always_ff @(posedge link_clk or negedge nrst) begin
        if (!nrst) begin
          sh_ff <= `DWIT_MIDSCALE; // R22 R24
        end else if (shadow_we && (chan_ff == gc[0])) begin
          sh_ff <= rx_ff; // R10 R23
        end
      end
      assign shadow[gc] = sh_ff;
    end
  endgenerate

  assign sda_o    = 1'b0;
  assign sda_oe_n = ~pull_ff; // R5 R13

  ////////////////////////////////////////////////////////////////////////////
  // System domain: event capture and outputs

  logic          tgl_s, seen_ff;
  logic          sys_park_ff, sys_chan_ff;
  logic [WW-1:0] wiper [NC];

  // Word is held for a whole byte time, far longer than the toggle latency
  dwit_pin_sync #(
    .W       (1),
    .RST_VAL (1'b0)
  ) u_evt_sync (
    .clk       (sys_clk),
    .nrst      (nrst),
    .pin_async (tgl_ff),
    .level     (tgl_s)
  );

  wire evt_take = (tgl_s != seen_ff);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      seen_ff     <= 1'b0;
      sys_park_ff <= 1'b0; // R24
      sys_chan_ff <= 1'b0;
    end else begin
      seen_ff <= tgl_s;
      if (evt_take) begin
        sys_park_ff <= evt_ff.park; // R8 R9
        sys_chan_ff <= evt_ff.chan; // R16
      end
    end
  end

  generate
    for (gc = 0; gc < NC; gc++) begin : g_wiper
      logic [WW-1:0] w_ff;
      always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          w_ff <= `DWIT_MIDSCALE; // R22
        end else if (evt_take && evt_ff.has_data && (evt_ff.chan == gc[0])) begin
          w_ff <= evt_ff.data; // R9 R10 R19
        end
      end
      assign wiper[gc] = w_ff;
    end
  endgenerate

  assign wiper_setting_1    = wiper[0];
  assign wiper_setting_2    = wiper[1];
  assign wiper_park         = sys_park_ff;
  assign channel_select_bit = sys_chan_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  AST_START_FRAME: assert property (@(posedge link_clk) disable iff (!nrst) // R1
    start_det |=> (st_ff == dwit_pkg::st_addr) && (cnt_ff == 4'h0))
    else $error("START did not open a frame");
  AST_STOP_IDLE: assert property (@(posedge link_clk) disable iff (!nrst) // R17
    stop_det |=> (st_ff == dwit_pkg::st_idle) && sda_oe_n)
    else $error("STOP did not return to idle");
  AST_IDLE_QUIET: assert property (@(posedge link_clk) disable iff (!nrst) // R5
    (st_ff == dwit_pkg::st_idle) |-> sda_oe_n)
    else $error("SDA driven while idle");
  AST_ADDR_ACK: assert property (@(posedge link_clk) disable iff (!nrst) // R4
    (byte_end && !start_det && !stop_det && (st_ff == dwit_pkg::st_addr) && addr_hit)
      |=> !sda_oe_n)
    else $error("Matching address not acknowledged");
  AST_SDA_LOW_PHASE: assert property (@(posedge link_clk) disable iff (!nrst) // R13
    ($changed(sda_oe_n) && !$past(start_det) && !$past(stop_det)) |-> (!scl_f && !scl_q_ff))
    else $error("SDA drive changed while SCL high");
  AST_READ_FOLLOWS: assert property (@(posedge link_clk) disable iff (!nrst) // R14
    (ack_end && !start_det && !stop_det && (st_ff == dwit_pkg::st_addr) && rw_ff)
      |=> (st_ff == dwit_pkg::st_read) && (cnt_ff == 4'h0) && (tx_ff == $past(shadow_sel)))
    else $error("Read data did not follow address acknowledge");
  AST_INSTR_FIELDS: assert property (@(posedge link_clk) disable iff (!nrst) // R7
    (byte_end && !start_det && !stop_det && (st_ff == dwit_pkg::st_instr))
      |=> (chan_ff == $past(rx_ff[7])) && (park_ff == $past(rx_ff[6])) && !sda_oe_n)
    else $error("Instruction fields not captured");
  AST_NO_DATA_KEEP: assert property (@(posedge sys_clk) disable iff (!nrst) // R16
    (evt_take && !evt_ff.has_data) |=> $stable(wiper_setting_1) && $stable(wiper_setting_2))
    else $error("Instruction-only write changed a setting");
  AST_DATA_LOAD: assert property (@(posedge sys_clk) disable iff (!nrst) // R19
    (evt_take && evt_ff.has_data && !evt_ff.chan) |=> (wiper_setting_1 == $past(evt_ff.data)))
    else $error("Data byte did not load channel 1");
  AST_PARK_OUT: assert property (@(posedge sys_clk) disable iff (!nrst) // R8
    evt_take |=> (wiper_park == $past(evt_ff.park)))
    else $error("Shutdown output does not follow instruction");
  COV_WRITE_DATA: cover property (@(posedge sys_clk) disable iff (!nrst)
    evt_take && evt_ff.has_data && evt_ff.chan);
  COV_READ_REPEAT: cover property (@(posedge link_clk) disable iff (!nrst)
    ack_end && (st_ff == dwit_pkg::st_read) && mack_ff);
  COV_MISMATCH: cover property (@(posedge link_clk) disable iff (!nrst)
    byte_end && (st_ff == dwit_pkg::st_addr) && !addr_hit);
  COV_PARK_WRITE: cover property (@(posedge sys_clk) disable iff (!nrst)
    evt_take && evt_ff.has_data && wiper_park);

endmodule

// ==== dwit_ctrl_model.sv ====
// Two-wire bus controller model: drives SCL, pulls SDA low on demand, reads resolved SDA.
// Assumes the bench resolves SDA with a pull-up and calls one task at a time.
`timescale 1ns/10ps

module dwit_ctrl_model (
  input  wire logic clk,      // Pacing clock
  input  wire logic sda,      // Resolved SDA level
  output logic      scl,      // SCL, stands high between frames
  output logic      sda_pull  // High pulls SDA low
);
  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Also serves as repeated START when SCL is low
  task automatic start();
    if (scl === 1'b0) begin
      sda_pull = 1'b0;
      tick(10);
      scl = 1'b1;
      tick(10);
    end
    sda_pull = 1'b1;
    tick(10);
    scl = 1'b0;
    tick(10);
  endtask

  task automatic stop();
    sda_pull = 1'b1;
    tick(10);
    scl = 1'b1;
    tick(10);
    sda_pull = 1'b0;
    tick(10);
  endtask

  // Phases of 100 ns, several link samples each, stay well above the target's filter delay
  task automatic bit_io(input logic b, output logic r);
    sda_pull = ~b;
    tick(10);
    scl = 1'b1;
    tick(10);
    r = sda;
    tick(10);
    scl = 1'b0;
    tick(10);
  endtask

  // Ninth pulse: a9 high releases SDA
  task automatic xfer(input logic [7:0] tx, input logic a9, output logic [7:0] rx,
                      output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(a9, ack);
  endtask
endmodule

// ==== tb.sv ====
// Self-checking bench for the dual wiper target, strap variant, random and corner frames.
// Assumes dwit_target and dwit_ctrl_model are compiled alongside.
`timescale 1ns/10ps
`include "dwit_params.svh"

module tb;
  logic                     sys_clk    = 1'b0;
  logic                     link_clk   = 1'b0;
  logic                     nrst       = 1'b0;
  logic                     scl;
  logic                     sda_pull;
  logic                     sda_o;
  logic                     sda_oe_n;
  logic [1:0]               strap      = 2'h0;
  logic [`DWIT_WIPER_W-1:0] wiper_setting_1;
  logic [`DWIT_WIPER_W-1:0] wiper_setting_2;
  logic                     wiper_park;
  logic                     channel_select_bit;
  logic                     quiet      = 1'b0;
  logic                     drove      = 1'b0;
  wire                      sda        = (sda_pull || (sda_oe_n === 1'b0 && sda_o === 1'b0)) ?
                                         1'b0 : 1'b1;
  int                       seed       = 63477;
  int                       n_mismatch = 0;
  int                       checks_done = 0;
  logic [7:0]               exp_w [2];
  logic                     exp_park;
  logic                     exp_ch;
  logic [7:0]               rx;
  logic [31:0]              r;
  logic                     ack;

  always #5 sys_clk = ~sys_clk;
  always #7.5 link_clk = ~link_clk;

  dwit_target #(.STRAP_EN(1'b1)) dwit_target_i (
    .sys_clk(sys_clk), .nrst(nrst), .link_clk(link_clk), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_n(sda_oe_n), .addr_strap_low(strap[0]),
    .addr_strap_high(strap[1]), .wiper_setting_1(wiper_setting_1),
    .wiper_setting_2(wiper_setting_2), .wiper_park(wiper_park),
    .channel_select_bit(channel_select_bit));

  dwit_ctrl_model dwit_ctrl_model_i (.clk(sys_clk), .sda(sda), .scl(scl), .sda_pull(sda_pull));

  // Any pull during a frame meant for another address is latched here
  always @(posedge sys_clk) if (quiet && sda_oe_n !== 1'b1) drove <= 1'b1;

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] addr_byte(input logic [1:0] s, input logic rd);
    return {`DWIT_UPPER_ADDR, s, rd};
  endfunction

  function automatic logic [7:0] instr(input logic ch, input logic pk);
    logic [31:0] j;
    j = $random(seed);
    return {ch, pk, j[5:0]};
  endfunction

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // Single-bit compare widened on purpose so no argument is padded silently
  task automatic chk1(input logic got, input logic exp, input string msg);
    chk({7'h00, got}, {7'h00, exp}, msg);
  endtask

  task automatic chk_outs();
    chk(wiper_setting_1, exp_w[0], "setting 1");
    chk(wiper_setting_2, exp_w[1], "setting 2");
    chk1(wiper_park, exp_park, "park");
    chk1(channel_select_bit, exp_ch, "channel");
  endtask

  task automatic head(input logic ch, input logic pk);
    dwit_ctrl_model_i.start();
    dwit_ctrl_model_i.xfer(addr_byte(strap, 1'b0), 1'b1, rx, ack);
    chk1(ack, 1'b0, "addr ack");
    dwit_ctrl_model_i.xfer(instr(ch, pk), 1'b1, rx, ack);
    chk1(ack, 1'b0, "instr ack");
    exp_ch   = ch;
    exp_park = pk;
  endtask

  task automatic wr(input logic ch, input logic pk, input int n);
    logic [31:0] d;
    head(ch, pk);
    for (int i = 0; i < n; i++) begin
      d = $random(seed);
      dwit_ctrl_model_i.xfer(d[7:0], 1'b1, rx, ack);
      chk1(ack, 1'b0, "data ack");
      exp_w[ch] = d[7:0];
      chk_outs();
    end
    dwit_ctrl_model_i.stop();
    chk_outs();
  endtask

  task automatic rd(input int n);
    dwit_ctrl_model_i.start();
    dwit_ctrl_model_i.xfer(addr_byte(strap, 1'b1), 1'b1, rx, ack);
    chk1(ack, 1'b0, "read addr ack");
    for (int i = 0; i < n; i++) begin
      dwit_ctrl_model_i.xfer(8'hFF, i == n - 1, rx, ack);
      chk(rx, exp_w[exp_ch], "read data");
    end
    dwit_ctrl_model_i.stop();
  endtask

  task automatic do_reset();
    exp_w    = '{`DWIT_MIDSCALE, `DWIT_MIDSCALE};
    exp_park = 1'b0;
    exp_ch   = 1'b0;
    @(negedge sys_clk);
    nrst = 1'b0;
    repeat (2) @(posedge link_clk);
    @(negedge sys_clk);
    nrst = 1'b1;
    chk_outs();
    chk1(sda_oe_n, 1'b1, "idle drive");
    repeat (20) @(negedge sys_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    r = $random(seed);
    strap = r[1:0];
    do_reset();
    wr(1'b0, 1'b0, 1);
    wr(1'b1, 1'b0, 3);
    wr(1'b0, 1'b1, 1);
    wr(1'b1, 1'b0, 0);
    rd(3);
    wr(1'b0, 1'b0, 0);
    rd(1);
    // Foreign address: nothing answers and nothing is stored
    quiet = 1'b1;
    dwit_ctrl_model_i.start();
    dwit_ctrl_model_i.xfer(addr_byte(~strap, 1'b0), 1'b1, rx, ack);
    chk1(ack, 1'b1, "foreign addr");
    dwit_ctrl_model_i.xfer(instr(1'b1, 1'b1), 1'b1, rx, ack);
    chk1(ack, 1'b1, "foreign instr");
    dwit_ctrl_model_i.stop();
    quiet = 1'b0;
    chk1(drove, 1'b0, "foreign drive");
    chk_outs();
    // Repeated START after the instruction goes straight to a read
    head(1'b1, 1'b0);
    rd(2);
    // STOP in mid data byte stores nothing
    head(1'b0, 1'b0);
    for (int i = 0; i < 4; i++) dwit_ctrl_model_i.bit_io(1'b0, ack);
    dwit_ctrl_model_i.stop();
    chk_outs();
    for (int k = 0; k < 4; k++) begin
      r = $random(seed);
      wr(r[0], r[1], 1 + r[3:2]);
      rd(2);
    end
    do_reset();
    print_verdict();
  end

  initial begin
    repeat (100000) @(posedge sys_clk);
    n_mismatch++;
    print_verdict();
  end
endmodule
